// ---- asr_pkg.sv ----
// Function
// [RULE1] Recover bits at x16, shift at bit rate
// [RULE2] Async reception starts only with receive enable
// [RULE3] Stop bit pushes word, raises ready flag
// [RULE4] Ready forwarded as interrupt when enabled
// [RULE5] Ready flag read-only, clears when buffer empty
// [RULE6] Two-word FIFO plus word in shifter
// [RULE7] Third word with full FIFO sets overrun
// [RULE8] Overrun clears only by receive enable toggle
// [RULE9] Overrun blocks all transfers into FIFO
// [RULE10] Low stop bit sets framing error
// [RULE11] Framing and ninth bit queued per word
// [RULE12] Software reads status before receive buffer
// [RULE13] Software follows documented reception setup order
// [RULE14] Software sets high-speed select with divisor
// [RULE15] Synchronous master mode is half-duplex
// [RULE16] Synchronous select bit enters synchronous mode
// [RULE17] Port enable assigns clock and data pins
// [RULE18] Clock source bit makes device drive clock
// [RULE19] NRZ frame, start, 8/9 bits LSB first, stop
// [RULE20] Baud is clock/(64 or 16 times divisor+1)
// [RULE21] High-speed select picks x16 or x64 baud clock
// [RULE22] Sleep halts all asynchronous activity
// [RULE23] Detect start edge, sample mid-bit
package asr_pkg;

  // Bus geometry; register index times four is the byte address
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam int DATA_W = 8;

  // Register indices
  localparam logic [IDX_W-1:0] IDX_IRQ_FLAGS = 10'h00C;
  localparam logic [IDX_W-1:0] IDX_RX_STATUS = 10'h018;
  localparam logic [IDX_W-1:0] IDX_TX_BUFFER = 10'h019;
  localparam logic [IDX_W-1:0] IDX_RX_BUFFER = 10'h01A;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLES = 10'h08C;
  localparam logic [IDX_W-1:0] IDX_TX_STATUS = 10'h098;
  localparam logic [IDX_W-1:0] IDX_BAUD_DIV = 10'h099;

  // Receive status and control fields
  localparam int RS_PORT_ENABLE = 7;
  localparam int RS_NINE_BIT = 6;
  localparam int RS_SINGLE_RX = 5;
  localparam int RS_CONT_RX = 4;
  localparam int RS_FRAMING = 2;
  localparam int RS_OVERRUN = 1;
  localparam int RS_NINTH = 0;

  // Transmit status and control fields
  localparam int TS_CLOCK_MASTER = 7;
  localparam int TS_NINE_BIT = 6;
  localparam int TS_TX_ENABLE = 5;
  localparam int TS_SYNC = 4;
  localparam int TS_HIGH_SPEED = 2;
  localparam int TS_SHIFT_EMPTY = 1;
  localparam int TS_NINTH = 0;

  // Flag and enable position of the receive ready event
  localparam int IRQ_RX_READY = 5;

  // Values after reset
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_TX_STATUS = 8'h02;

  // Baud generator and data recovery counts
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam logic [1:0] PRESCALE_HALF = 2'h1;
  localparam logic [3:0] OVS_HALF_BIT = 4'h7;
  localparam logic [3:0] OVS_FULL_BIT = 4'hF;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  localparam int RX_FIFO_DEPTH = 2;

  typedef enum logic [1:0] {
    ASR_IDLE,
    ASR_START,
    ASR_DATA,
    ASR_STOP
  } asr_rx_state_t;

  typedef struct packed {
    logic framing;
    logic ninth;
    logic [DATA_W-1:0] data;
  } asr_rx_word_t;

  localparam int RX_WORD_W = $bits(asr_rx_word_t);

endpackage

// ---- asr_baud_gen.sv ----
`timescale 1ns/10ps
module asr_baud_gen (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Control
  input wire logic run,
  input wire logic high_speed,
  input wire logic [asr_pkg::DATA_W-1:0] divisor,
  // Ticks
  output logic ovs_tick,
  output logic sync_toggle
);
  import asr_pkg::*;

  logic [DATA_W-1:0] div_count;
  logic [1:0] prescale;
  logic wrap;

  assign wrap = (div_count == '0);

  // Held in reset while no enable is set, so a slow rate starts clean
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_count <= '0;
      prescale <= '0;
    end else if (!run) begin
      div_count <= divisor;
      prescale <= '0;
    end else if (wrap) begin
      div_count <= divisor;
      prescale <= prescale + 2'h1;
    end else begin
      div_count <= div_count - 8'h01;
    end
  end

  // x16 of bit rate: clock/(n+1) at high speed, clock/(4(n+1)) otherwise
  always_comb begin
    ovs_tick = run && wrap && (high_speed || prescale == PRESCALE_LAST); // [RULE20] [RULE21]
    sync_toggle = run && wrap && (prescale == PRESCALE_HALF || prescale == PRESCALE_LAST);
  end

endmodule

// ---- asr_rx_fifo.sv ----
`timescale 1ns/10ps
module asr_rx_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Fill side
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  // Drain side
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic full,
  output logic empty
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic do_push;
  logic do_pop;

  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign full = (count == FULL_COUNT);
  assign empty = (count == '0);
  assign head = mem[rd_ptr];

  always_ff @(posedge clock) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + AW'(1);
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + AW'(1);
      end
      if (do_push && !do_pop) begin
        count <= count + (AW + 1)'(1);
      end else if (do_pop && !do_push) begin
        count <= count - (AW + 1)'(1);
      end
    end
  end

endmodule

// ---- asr_top.sv ----
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
module asr_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [asr_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Receive data pin
  input wire logic receive_data_pin_in,
  output logic receive_data_pin_out,
  output logic receive_data_pin_oe_n,
  // Transmit clock pin
  output logic transmit_clock_pin_out,
  output logic transmit_clock_pin_oe_n,
  // System
  input wire logic sleep_active,
  output logic rx_irq,
  output logic tx_inhibit
);
  import asr_pkg::*;

  // Reset release
  logic rst_meta_n;
  logic reset_n;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      reset_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      reset_n <= rst_meta_n;
    end
  end

  // Control registers
  logic serial_port_enable;
  logic nine_bit_receive_select;
  logic single_receive_enable;
  logic continuous_receive_enable;
  logic clock_source_master;
  logic nine_bit_transmit_select;
  logic transmit_enable;
  logic sync_select;
  logic high_speed_baud_select;
  logic tx_ninth_bit;
  logic [DATA_W-1:0] baud_divisor;
  logic [DATA_W-1:0] peripheral_irq_enables;
  logic [DATA_W-1:0] transmit_buffer;

  // Receive state
  logic overrun_error_flag;
  logic rx_ready_flag;
  logic fifo_full;
  logic fifo_empty;
  logic fifo_push;
  logic fifo_pop;
  asr_rx_word_t fifo_head;
  asr_rx_word_t done_word;

  // Bus state
  logic addr_phase;
  logic wr_pending;
  logic rd_pending;
  logic [IDX_W-1:0] wr_idx;
  logic [IDX_W-1:0] rd_idx;
  logic [IDX_W-1:0] addr_idx;
  logic addr_in_range;

  // ---------------------------------------------------------------
  // AHB-Lite slave: writes take no wait, reads take one wait state
  // ---------------------------------------------------------------
  assign addr_phase = hsel && hready && htrans[1];
  assign addr_idx = haddr[IDX_W+1:2];
  assign addr_in_range = (haddr[1:0] == 2'h0);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_pending <= 1'b0;
      rd_pending <= 1'b0;
      wr_idx <= '0;
      rd_idx <= '0;
      hreadyout <= 1'b1;
    end else begin
      wr_pending <= addr_phase && hwrite && addr_in_range;
      rd_pending <= addr_phase && !hwrite;
      if (addr_phase) begin
        wr_idx <= addr_idx;
        rd_idx <= addr_in_range ? addr_idx : '1;
      end
      // The wait lets a preceding write land before its read-back
      hreadyout <= !(addr_phase && !hwrite);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  function automatic logic [DATA_W-1:0] read_value(input logic [IDX_W-1:0] idx);
    logic [DATA_W-1:0] v;
    v = '0;
    case (idx)
      IDX_IRQ_FLAGS: v[IRQ_RX_READY] = rx_ready_flag; // [RULE5]
      IDX_RX_STATUS: begin
        v[RS_PORT_ENABLE] = serial_port_enable;
        v[RS_NINE_BIT] = nine_bit_receive_select;
        v[RS_SINGLE_RX] = single_receive_enable;
        v[RS_CONT_RX] = continuous_receive_enable;
        v[RS_FRAMING] = !fifo_empty && fifo_head.framing; // [RULE11]
        v[RS_OVERRUN] = overrun_error_flag;
        v[RS_NINTH] = !fifo_empty && fifo_head.ninth; // [RULE11]
      end
      IDX_TX_BUFFER: v = transmit_buffer;
      IDX_RX_BUFFER: v = fifo_empty ? RST_ZERO : fifo_head.data;
      IDX_IRQ_ENABLES: v = peripheral_irq_enables;
      IDX_TX_STATUS: begin
        v[TS_CLOCK_MASTER] = clock_source_master;
        v[TS_NINE_BIT] = nine_bit_transmit_select;
        v[TS_TX_ENABLE] = transmit_enable;
        v[TS_SYNC] = sync_select;
        v[TS_HIGH_SPEED] = high_speed_baud_select;
        // No transmit shifter here, so it always reads empty
        v[TS_SHIFT_EMPTY] = 1'b1;
        v[TS_NINTH] = tx_ninth_bit;
      end
      IDX_BAUD_DIV: v = baud_divisor;
      default: v = '0;
    endcase
    return v;
  endfunction

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= '0;
    end else if (rd_pending) begin
      hrdata <= {24'h000000, read_value(rd_idx)};
    end
  end

  // Reading the buffer advances to the next entry with its own flags
  assign fifo_pop = rd_pending && (rd_idx == IDX_RX_BUFFER); // [RULE11] [RULE5]

  // Register writes; flags and reserved bits ignore writes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      serial_port_enable <= 1'b0;
      nine_bit_receive_select <= 1'b0;
      single_receive_enable <= 1'b0;
      continuous_receive_enable <= 1'b0;
    end else if (wr_pending && wr_idx == IDX_RX_STATUS) begin
      serial_port_enable <= hwdata[RS_PORT_ENABLE];
      nine_bit_receive_select <= hwdata[RS_NINE_BIT];
      single_receive_enable <= hwdata[RS_SINGLE_RX];
      continuous_receive_enable <= hwdata[RS_CONT_RX];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clock_source_master <= RST_TX_STATUS[TS_CLOCK_MASTER];
      nine_bit_transmit_select <= RST_TX_STATUS[TS_NINE_BIT];
      transmit_enable <= RST_TX_STATUS[TS_TX_ENABLE];
      sync_select <= RST_TX_STATUS[TS_SYNC];
      high_speed_baud_select <= RST_TX_STATUS[TS_HIGH_SPEED];
      tx_ninth_bit <= RST_TX_STATUS[TS_NINTH];
    end else if (wr_pending && wr_idx == IDX_TX_STATUS) begin
      clock_source_master <= hwdata[TS_CLOCK_MASTER];
      nine_bit_transmit_select <= hwdata[TS_NINE_BIT];
      transmit_enable <= hwdata[TS_TX_ENABLE];
      sync_select <= hwdata[TS_SYNC];
      high_speed_baud_select <= hwdata[TS_HIGH_SPEED];
      tx_ninth_bit <= hwdata[TS_NINTH];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      baud_divisor <= RST_ZERO;
      peripheral_irq_enables <= RST_ZERO;
      transmit_buffer <= RST_ZERO;
    end else if (wr_pending) begin
      case (wr_idx)
        IDX_BAUD_DIV: baud_divisor <= hwdata[DATA_W-1:0];
        IDX_IRQ_ENABLES: peripheral_irq_enables <= hwdata[DATA_W-1:0];
        IDX_TX_BUFFER: transmit_buffer <= hwdata[DATA_W-1:0];
        default: transmit_buffer <= transmit_buffer;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Baud generator
  // ---------------------------------------------------------------
  logic brg_run;
  logic ovs_tick;
  logic sync_toggle;

  assign brg_run = (transmit_enable || continuous_receive_enable || single_receive_enable)
                   && !sleep_active; // [RULE22]

  asr_baud_gen u_baud (
    .clock(clock),
    .reset_n(reset_n),
    .run(brg_run),
    .high_speed(high_speed_baud_select),
    .divisor(baud_divisor),
    .ovs_tick(ovs_tick),
    .sync_toggle(sync_toggle)
  );

  // ---------------------------------------------------------------
  // Data recovery and receive shift register
  // ---------------------------------------------------------------
  logic rx_meta;
  logic rx_sync;
  logic rx_prev;
  logic rx_enable;
  asr_rx_state_t rx_state;
  logic [3:0] ovs_count;
  logic [3:0] bit_count;
  logic [8:0] rx_shift_register;
  logic frame_done;
  logic frame_stop_bad;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= receive_data_pin_in;
      rx_sync <= rx_meta;
    end
  end

  // Async receiver needs port enable, async mode and continuous enable
  assign rx_enable = serial_port_enable && !sync_select && continuous_receive_enable; // [RULE2] [RULE16]

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_prev <= 1'b1;
    end else if (ovs_tick) begin
      rx_prev <= rx_sync;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_state <= ASR_IDLE;
      ovs_count <= '0;
      bit_count <= '0;
      rx_shift_register <= '0;
      frame_done <= 1'b0;
      frame_stop_bad <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (!rx_enable) begin
        rx_state <= ASR_IDLE;
        ovs_count <= '0;
        bit_count <= '0;
      end else if (ovs_tick) begin // [RULE1] [RULE22]
        ovs_count <= ovs_count + 4'h1;
        case (rx_state)
          ASR_IDLE: begin
            ovs_count <= '0;
            if (rx_prev && !rx_sync) begin // [RULE23]
              rx_state <= ASR_START;
            end
          end
          ASR_START: begin
            if (ovs_count == OVS_HALF_BIT) begin
              ovs_count <= '0;
              bit_count <= '0;
              // A glitch that is high at mid start is not a frame
              rx_state <= rx_sync ? ASR_IDLE : ASR_DATA; // [RULE23]
            end
          end
          ASR_DATA: begin
            if (ovs_count == OVS_FULL_BIT) begin
              // Shifter advances once per bit, LSB first
              rx_shift_register <= {rx_sync, rx_shift_register[8:1]}; // [RULE1] [RULE19]
              bit_count <= bit_count + 4'h1;
              if (bit_count == (nine_bit_receive_select ? BITS_NINE : BITS_EIGHT) - 4'h1) begin
                rx_state <= ASR_STOP;
              end
            end
          end
          ASR_STOP: begin
            if (ovs_count == OVS_FULL_BIT) begin
              frame_done <= 1'b1;
              frame_stop_bad <= !rx_sync; // [RULE10]
              rx_state <= ASR_IDLE;
            end
          end
          default: rx_state <= ASR_IDLE;
        endcase
      end
    end
  end

  // Eight-bit frames leave data one place higher in the shifter
  always_comb begin
    done_word.framing = frame_stop_bad; // [RULE10] [RULE11]
    done_word.ninth = nine_bit_receive_select && rx_shift_register[8]; // [RULE11]
    done_word.data = nine_bit_receive_select ? rx_shift_register[7:0] : rx_shift_register[8:1];
  end

  // ---------------------------------------------------------------
  // Receive FIFO, overrun and ready
  // ---------------------------------------------------------------
  assign fifo_push = frame_done && !overrun_error_flag && !fifo_full; // [RULE3] [RULE9]

  asr_rx_fifo #(
    .WIDTH(RX_WORD_W),
    .DEPTH(RX_FIFO_DEPTH)
  ) u_fifo ( // [RULE6]
    .clock(clock),
    .reset_n(reset_n),
    .push(fifo_push),
    .push_data(done_word),
    .pop(fifo_pop),
    .head(fifo_head),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  // Pop and a full-FIFO stop can meet; the word is still lost then
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      overrun_error_flag <= 1'b0;
    end else if (frame_done && fifo_full && rx_enable) begin
      overrun_error_flag <= 1'b1; // [RULE7]
    end else if (!continuous_receive_enable) begin
      overrun_error_flag <= 1'b0; // [RULE8]
    end
  end

  assign rx_ready_flag = !fifo_empty; // [RULE3] [RULE5]

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_irq <= 1'b0;
    end else begin
      rx_irq <= rx_ready_flag && peripheral_irq_enables[IRQ_RX_READY]; // [RULE4]
    end
  end

  // ---------------------------------------------------------------
  // Pin assignment and synchronous master clock
  // ---------------------------------------------------------------
  logic clock_drive;

  assign clock_drive = serial_port_enable && sync_select && clock_source_master; // [RULE17] [RULE18]

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      transmit_clock_pin_oe_n <= 1'b1;
      transmit_clock_pin_out <= 1'b0;
    end else begin
      transmit_clock_pin_oe_n <= !clock_drive; // [RULE18]
      if (!clock_drive || !brg_run) begin
        transmit_clock_pin_out <= 1'b0;
      end else if (sync_toggle) begin
        transmit_clock_pin_out <= !transmit_clock_pin_out;
      end
    end
  end

  // Receive pin is only ever sampled here; no transmitter drives it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      receive_data_pin_oe_n <= 1'b1;
      receive_data_pin_out <= 1'b0;
    end else begin
      receive_data_pin_oe_n <= 1'b1;
      receive_data_pin_out <= 1'b0;
    end
  end

  // With the port enabled, any receive enable in synchronous mode holds off transmission
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_inhibit <= 1'b0;
    end else begin
      tx_inhibit <= serial_port_enable && sync_select
                    && (continuous_receive_enable || single_receive_enable); // [RULE15]
    end
  end

endmodule

// ---- asr_checker.sv ----
`timescale 1ns/10ps
module asr_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Pins and system
  input wire logic receive_data_pin_out,
  input wire logic receive_data_pin_oe_n,
  input wire logic transmit_clock_pin_out,
  input wire logic transmit_clock_pin_oe_n,
  input wire logic sleep_active,
  input wire logic rx_irq,
  input wire logic tx_inhibit
);
  logic taken;
  logic [3:0] acc_age;
  logic [3:0] wr_age;
  logic [3:0] sleep_len;
  assign taken = hsel && hready && htrans[1];
  // Ages saturate, no wrap
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_age <= 4'hF;
      wr_age <= 4'hF;
      sleep_len <= 4'h0;
    end else begin
      acc_age <= taken ? 4'h0 : ((acc_age == 4'hF) ? acc_age : acc_age + 4'h1);
      wr_age <= (taken && hwrite) ? 4'h0 : ((wr_age == 4'hF) ? wr_age : wr_age + 4'h1);
      sleep_len <= !sleep_active ? 4'h0 : ((sleep_len == 4'hF) ? sleep_len : sleep_len + 4'h1);
    end
  end
  a_resp_okay: assert property (@(posedge clock) disable iff (!rst_n) hresp == 1'b0)
    else $error("bus response not OKAY");
  a_read_wait: assert property (@(posedge clock) disable iff (!rst_n)
    taken && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  a_write_ready: assert property (@(posedge clock) disable iff (!rst_n)
    taken && hwrite |=> hreadyout) else $error("write stalled");
  a_rdata_upper: assert property (@(posedge clock) disable iff (!rst_n) hrdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_data_pin_idle: assert property (@(posedge clock) disable iff (!rst_n)
    receive_data_pin_oe_n && !receive_data_pin_out) else $error("receive pin driven");
  a_irq_drop_cause: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(rx_irq) |-> acc_age < 4'h8) else $error("interrupt dropped without access");
  a_inhibit_cause: assert property (@(posedge clock) disable iff (!rst_n)
    $changed(tx_inhibit) |-> wr_age < 4'h6) else $error("inhibit changed without write");
  a_clock_drive_cause: assert property (@(posedge clock) disable iff (!rst_n)
    $changed(transmit_clock_pin_oe_n) |-> wr_age < 4'h6) else $error("clock drive changed without write");
  a_sleep_freeze: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(rx_irq) |-> sleep_len < 4'h6 || wr_age < 4'h6) else $error("word received while asleep");
  a_clock_park: assert property (@(posedge clock) disable iff (!rst_n)
    transmit_clock_pin_oe_n |-> !transmit_clock_pin_out) else $error("clock toggles while not driven");
endmodule

bind asr_top asr_checker i_checker (.clock(clock), .rst_n(rst_n), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .receive_data_pin_out(receive_data_pin_out),
  .receive_data_pin_oe_n(receive_data_pin_oe_n), .transmit_clock_pin_out(transmit_clock_pin_out),
  .transmit_clock_pin_oe_n(transmit_clock_pin_oe_n), .sleep_active(sleep_active), .rx_irq(rx_irq),
  .tx_inhibit(tx_inhibit));

// ---- asr_tx_model.sv ----
`timescale 1ns/10ps
module asr_tx_model (
  // Clock
  input wire logic clock,
  // Request
  input wire logic go,
  input wire logic [8:0] word,
  input wire logic nine,
  input wire logic stop_level,
  input wire logic [7:0] bit_clks,
  // Line
  output logic line,
  output logic busy
);
  int i;
  // Idle line high
  initial begin
    line = 1'b1;
    busy = 1'b0;
  end
  task automatic hold_bit(input logic level);
    line <= level;
    repeat (bit_clks) @(posedge clock);
  endtask
  always begin
    @(posedge clock);
    if (go) begin
      busy <= 1'b1;
      hold_bit(1'b0);
      for (i = 0; i < (nine ? 9 : 8); i++) begin
        hold_bit(word[i]);
      end
      hold_bit(stop_level);
      line <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule

// ---- asr_top_tb.sv ----
`timescale 1ns/10ps
module asr_top_tb;
  import asr_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, sleep_active = 1'b0;
  logic go = 1'b0, nine = 1'b0, stop_level = 1'b1;
  logic [ADDR_W-1:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic [8:0] word = 9'h000;
  logic [7:0] bit_clks = 8'h20;
  logic hready, hreadyout, hresp, clk_oe_n, rx_irq, tx_inhibit, line, busy;
  logic [31:0] hrdata;
  int n_errors = 0;
  int n_compared = 0;
  assign hready = hreadyout;
  always #2.5 clock = ~clock;
  asr_top i_dut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .receive_data_pin_in(line), .receive_data_pin_out(), .receive_data_pin_oe_n(),
    .transmit_clock_pin_out(), .transmit_clock_pin_oe_n(clk_oe_n), .sleep_active(sleep_active),
    .rx_irq(rx_irq), .tx_inhibit(tx_inhibit));
  asr_tx_model i_tx (.clock(clock), .go(go), .word(word), .nine(nine), .stop_level(stop_level),
    .bit_clks(bit_clks), .line(line), .busy(busy));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
    n_compared++;
    if ((got & mask) !== (exp & mask)) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {idx, 2'h0};
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Lets registered outputs settle
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    xfer(1'b1, idx, d, rd);
    repeat (3) @(posedge clock);
  endtask
  task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    logic [31:0] rd;
    xfer(1'b0, idx, 8'h00, rd);
    chk(rd, {24'h000000, e}, {24'hFFFFFF, m});
  endtask
  task automatic send(input logic [8:0] w, input logic s);
    word <= w;
    stop_level <= s;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    do @(posedge clock); while (busy === 1'b1);
    repeat (6) @(posedge clock);
  endtask
  task automatic t_reset();
    rd_chk(IDX_IRQ_FLAGS, RST_ZERO);
    rd_chk(IDX_RX_STATUS, RST_ZERO, 8'hFE);
    rd_chk(IDX_RX_BUFFER, RST_ZERO);
    rd_chk(IDX_IRQ_ENABLES, RST_ZERO);
    rd_chk(IDX_TX_STATUS, RST_TX_STATUS);
    rd_chk(IDX_BAUD_DIV, RST_ZERO);
    rd_chk(10'h3FF, 8'h00);
    wr(IDX_TX_BUFFER, 8'h5C);
    rd_chk(IDX_TX_BUFFER, 8'h5C);
    wr(IDX_IRQ_FLAGS, 8'hFF);
    rd_chk(IDX_IRQ_FLAGS, 8'h00);
  endtask
  task automatic t_enable();
    wr(IDX_BAUD_DIV, 8'h01);
    wr(IDX_TX_STATUS, 8'h04);
    rd_chk(IDX_TX_STATUS, 8'h06);
    wr(IDX_RX_STATUS, 8'h80);
    send(9'h0A5, 1'b1);
    rd_chk(IDX_IRQ_FLAGS, 8'h00);
    wr(IDX_IRQ_ENABLES, 8'h20);
    wr(IDX_RX_STATUS, 8'h90);
    send(9'h0A5, 1'b1);
    rd_chk(IDX_IRQ_FLAGS, 8'h20);
    chk({31'h0, rx_irq}, 32'h1, 32'h1);
    rd_chk(IDX_RX_STATUS, 8'h90, 8'hFE);
    rd_chk(IDX_RX_BUFFER, 8'hA5);
    rd_chk(IDX_IRQ_FLAGS, 8'h00);
    chk({31'h0, rx_irq}, 32'h0, 32'h1);
  endtask
  task automatic t_overrun();
    send(9'h03C, 1'b1);
    send(9'h05A, 1'b0);
    send(9'h077, 1'b1);
    rd_chk(IDX_RX_STATUS, 8'h92, 8'hFE);
    rd_chk(IDX_RX_BUFFER, 8'h3C);
    rd_chk(IDX_RX_STATUS, 8'h96, 8'hFE);
    rd_chk(IDX_RX_BUFFER, 8'h5A);
    send(9'h011, 1'b1);
    rd_chk(IDX_IRQ_FLAGS, 8'h00);
    rd_chk(IDX_RX_STATUS, 8'h92, 8'hFA);
    wr(IDX_RX_STATUS, 8'h80);
    wr(IDX_RX_STATUS, 8'h90);
    rd_chk(IDX_RX_STATUS, 8'h90, 8'hFA);
  endtask
  task automatic t_nine_mask();
    wr(IDX_RX_STATUS, 8'hD0);
    nine <= 1'b1;
    send(9'h1AB, 1'b1);
    send(9'h054, 1'b1);
    rd_chk(IDX_RX_STATUS, 8'hD1);
    rd_chk(IDX_RX_BUFFER, 8'hAB);
    rd_chk(IDX_RX_STATUS, 8'hD0);
    rd_chk(IDX_RX_BUFFER, 8'h54);
    nine <= 1'b0;
    wr(IDX_RX_STATUS, 8'h90);
    wr(IDX_IRQ_ENABLES, 8'h00);
    send(9'h0C3, 1'b1);
    rd_chk(IDX_IRQ_FLAGS, 8'h20);
    chk({31'h0, rx_irq}, 32'h0, 32'h1);
    rd_chk(IDX_RX_BUFFER, 8'hC3);
  endtask
  task automatic t_speed();
    wr(IDX_TX_STATUS, 8'h00);
    wr(IDX_BAUD_DIV, 8'h00);
    bit_clks <= 8'h40;
    send(9'h096, 1'b1);
    rd_chk(IDX_RX_BUFFER, 8'h96);
  endtask
  task automatic t_sync();
    wr(IDX_TX_STATUS, 8'h10);
    chk({31'h0, tx_inhibit}, 32'h1, 32'h1);
    chk({31'h0, clk_oe_n}, 32'h1, 32'h1);
    send(9'h0E1, 1'b1);
    rd_chk(IDX_IRQ_FLAGS, 8'h00);
    wr(IDX_TX_STATUS, 8'h90);
    chk({31'h0, clk_oe_n}, 32'h0, 32'h1);
    wr(IDX_RX_STATUS, 8'h10);
    chk({31'h0, clk_oe_n}, 32'h1, 32'h1);
    chk({31'h0, tx_inhibit}, 32'h0, 32'h1);
  endtask
  task automatic t_sleep();
    wr(IDX_TX_STATUS, 8'h00);
    wr(IDX_IRQ_ENABLES, 8'h20);
    wr(IDX_RX_STATUS, 8'h90);
    sleep_active <= 1'b1;
    send(9'h0F0, 1'b1);
    rd_chk(IDX_IRQ_FLAGS, 8'h00);
    sleep_active <= 1'b0;
    send(9'h00F, 1'b1);
    rd_chk(IDX_RX_BUFFER, 8'h0F);
  endtask
  task automatic report_and_stop();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset();
    t_enable();
    t_overrun();
    t_nine_mask();
    t_speed();
    t_sync();
    t_sleep();
    report_and_stop();
  end
  // Some three times the run
  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end
endmodule
